// file: src/tmb_timer.sv
// Operation
// - 16-bit up count, wrap sets overflow
// - Interrupt only while overflow enable set
// - Reset: stopped, control all zero
// - Bit 7 selects one 16-bit access
// - Two-bit field picks capture time base
// - Prescale 1, 2, 4 or 8
// - Bit 2 bypasses external clock sync
// - Sync bit ignored for internal clock
// - External count on rise after fall
// - Internal clock counts once per four-clock instruction cycle
// - Run bit 0 gates counting
// - Timer, sync and async counter modes
// - Oscillator enable forces pins input
// - Internal reset input clears count
// - Special event mode 1011 resets, no flag
// - Counter byte writes beat special event reset
`timescale 1ns/1ps
`default_nettype none

module tmb_timer
    import tmb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Count clock sources
    input  wire logic        external_count_input,
    input  wire logic        secondary_osc_in,
    // Compare unit special event
    input  wire logic [3:0]  compare_unit_mode,
    input  wire logic        compare_match,
    // Port pin direction
    input  wire logic [1:0]  port_c_direction,
    output logic [1:0]       osc_pin_dir,
    // Time base and count to the capture/compare units
    output logic [15:0]      count_value,
    output logic             base_unit1,
    output logic             base_unit2,
    // Interrupt
    output logic             irq
);

    // Register map, byte offsets on the bus:
    //   control, count low, count high,
    //   status, clear, enable, auxiliary.
    // Unmapped offsets answer with pslverr.
    // Status is read only; writes are dropped.
    // Clear is write only and reads as zero.
    //
    // Bus timing
    //   Every transfer costs two cycles:
    //   setup, then one access cycle.
    //   pready is a registered pulse that
    //   stands in the access cycle only.
    //   Read data is latched at the setup
    //   edge, so a tick that lands during
    //   the access cycle shows up only in
    //   the next read.
    //   Writes land at the access edge.

    tmb_core_t  r;
    tmb_core_t  n;
    tmb_mode_t  mode;
    tmb_tick_if tif ();

    logic        setup;
    logic        acc_wr;
    logic        wide;
    logic        special_evt;
    logic        wr_lo;
    logic        wr_hi;
    logic        ovf_set;
    logic [16:0] inc;

    // Clock source front-end and prescaler
    tmb_front #(
        .CYC_DIV (`TMB_CYC_DIV)
    ) u_front (
        .clk  (clk),
        .nrst (nrst),
        .tif  (tif)
    );

    tmb_presc u_presc (
        .clk  (clk),
        .nrst (nrst),
        .tif  (tif)
    );

    // Mode is decoded, not stored, so the
    // auxiliary register shows it at once.
    //
    // Mode from source and sync bits
    always_comb begin
        if (!r.ctrl[`TMB_B_SRC]) begin
            mode = TMB_MODE_TIMER;
        end else if (r.ctrl[`TMB_B_SYNC_BYP]) begin
            mode = TMB_MODE_ASYNC_CNT;
        end else begin
            mode = TMB_MODE_SYNC_CNT;
        end
    end

    // The sync bypass only matters for the
    // external source; the front-end
    // ignores it on the internal clock.
    //
    // Controls toward the tick path
    // External source choice
    assign tif.use_ext     = r.ctrl[`TMB_B_SRC];
    assign tif.sync_bypass = (mode == TMB_MODE_ASYNC_CNT);
    assign tif.run         = r.ctrl[`TMB_B_RUN];
    // Oscillator pin wins over the count pin when enabled
    assign tif.ext_level   = r.osc_en ? secondary_osc_in : external_count_input;
    assign tif.ratio       = {r.ctrl[`TMB_B_PRE_HI], r.ctrl[`TMB_B_PRE_LO]};
    assign tif.clear       = r.presc_clr;

    // The access write strobe needs the
    // registered ready, so a stray
    // penable without setup writes nothing.
    //
    // Bus phase decode
    assign setup  = psel && !penable;
    assign acc_wr = psel && penable && pwrite && r.pready;
    assign wide   = r.ctrl[`TMB_B_WIDE];
    assign wr_lo  = acc_wr && (paddr == `TMB_OFF_CNT_LO);
    assign wr_hi  = acc_wr && (paddr == `TMB_OFF_CNT_HI);

    assign special_evt = compare_match && (compare_unit_mode == `TMB_SPECIAL_EVT);

    // Counting path
    //   The front-end turns the chosen
    //   source into single-cycle ticks.
    //   The prescaler passes one tick in
    //   one, two, four or eight.
    //   The core adds one per passed tick.
    //   Latency from a source edge to the
    //   count is fixed, so rates stay exact.
    //
    // Event reset
    //   A special event forces zero and
    //   never marks an overflow.
    //   It is honoured in all modes; the
    //   unsynchronised source is still
    //   sampled on the core clock here,
    //   so the clear still acts there.
    //
    // Priority inside one cycle
    //   1. count tick
    //   2. special event reset
    //   3. software writes to the count
    //   Later steps overwrite earlier
    //   ones, so written count bytes win.
    //
    // Wide access
    //   A low read copies the live high
    //   byte into the buffer; a high read
    //   then returns that copy, so both
    //   halves come from one instant.
    //   High writes park in the buffer
    //   and a low write loads both.
    //   Only low writes clear the
    //   prescaler, never high writes.

    // Next-state logic
    always_comb begin
        n           = r;
        n.presc_clr = 1'b0;
        n.pready    = 1'b0;
        n.pslverr   = 1'b0;
        inc         = {1'b0, r.count} + 17'h0_0001;
        ovf_set     = 1'b0;

        if (tif.out_tick) begin
            n.count = inc[15:0];
            ovf_set = (r.count == `TMB_CNT_MAX);
        end

        if (special_evt) begin
            n.count = `TMB_CNT_RST;
            ovf_set = 1'b0;
        end

        // Setup phase: read data and answer prepared one cycle ahead
        if (setup) begin
            n.pready = 1'b1;
            n.prdata = `TMB_WORD_ZERO;
            if (!pwrite) begin
                unique case (paddr)
                    `TMB_OFF_CTRL: begin
                        n.prdata[7:0] = r.ctrl;
                    end
                    `TMB_OFF_CNT_LO: begin
                        n.prdata[7:0] = r.count[7:0];
                        if (wide) begin
                            n.hbuf = r.count[15:8];
                        end
                    end
                    `TMB_OFF_CNT_HI: begin
                        n.prdata[7:0] = wide ? r.hbuf : r.count[15:8];
                    end
                    `TMB_OFF_IRQ_STAT: begin
                        n.prdata[`TMB_B_OVF] = r.ovf_stat;
                    end
                    `TMB_OFF_IRQ_CLR: begin
                        n.prdata = `TMB_WORD_ZERO;
                    end
                    `TMB_OFF_IRQ_EN: begin
                        n.prdata[`TMB_B_OVF] = r.ovf_en;
                    end
                    `TMB_OFF_AUX: begin
                        n.prdata[`TMB_B_OSC_EN]                 = r.osc_en;
                        n.prdata[`TMB_B_MODE_HI:`TMB_B_MODE_LO] = mode;
                    end
                    default: begin
                        n.pslverr = 1'b1;
                    end
                endcase
            end else begin
                unique case (paddr)
                    `TMB_OFF_CTRL, `TMB_OFF_CNT_LO, `TMB_OFF_CNT_HI, `TMB_OFF_IRQ_STAT,
                    `TMB_OFF_IRQ_CLR, `TMB_OFF_IRQ_EN, `TMB_OFF_AUX: begin
                        n.pslverr = 1'b0;
                    end
                    default: begin
                        n.pslverr = 1'b1;
                    end
                endcase
            end
        end

        // Access phase writes; they come after the event so they take priority
        if (acc_wr && paddr == `TMB_OFF_CTRL) begin
            n.ctrl = pwdata[7:0];
        end
        if (wr_lo) begin
            n.count     = wide ? {r.hbuf, pwdata[7:0]} : {n.count[15:8], pwdata[7:0]};
            n.presc_clr = 1'b1;
            ovf_set     = 1'b0;
        end
        if (wr_hi) begin
            if (wide) begin
                n.hbuf = pwdata[7:0];
            end else begin
                n.count[15:8] = pwdata[7:0];
                ovf_set       = 1'b0;
            end
        end
        if (acc_wr && paddr == `TMB_OFF_IRQ_EN) begin
            n.ovf_en = pwdata[`TMB_B_OVF];
        end
        if (acc_wr && paddr == `TMB_OFF_AUX) begin
            n.osc_en = pwdata[`TMB_B_OSC_EN];
        end

        // Sticky flag; a set in the clearing cycle is kept
        if (acc_wr && paddr == `TMB_OFF_IRQ_CLR && pwdata[`TMB_B_OVF]) begin
            n.ovf_stat = 1'b0;
        end
        if (ovf_set) begin
            n.ovf_stat = 1'b1;
        end

        n.irq = n.ovf_stat && n.ovf_en;

        n.base_unit1 = n.ctrl[`TMB_B_BASE_HI];
        n.base_unit2 = n.ctrl[`TMB_B_BASE_HI] || n.ctrl[`TMB_B_BASE_LO];

        n.osc_pin_dir = n.osc_en ? 2'h3 : port_c_direction;
    end

    // Sticky overflow flag
    //   Set by a wrap, cleared by a one
    //   in the clear register. When both
    //   fall in one cycle the set wins,
    //   so a clear never loses an overflow.
    //   The interrupt is the flag masked
    //   by its enable, in the same cycle.
    //
    // Time base select
    //   The high select bit hands both
    //   capture units to this timer; the
    //   low bit alone hands over unit two.
    //
    // Oscillator pins
    //   With the oscillator on, both pins
    //   are inputs whatever the port
    //   direction bits say.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r       <= '0;
            r.ctrl  <= `TMB_CTRL_RST;
            r.count <= `TMB_CNT_RST;
        end else begin
            r <= n;
        end
    end

    // Every output is a flip-flop; none
    // depends on a bus input in the same
    // cycle.
    //
    // Outputs straight from the state register
    assign prdata      = r.prdata;
    assign pready      = r.pready;
    assign pslverr     = r.pslverr;
    assign irq         = r.irq;
    assign count_value = r.count;
    assign base_unit1  = r.base_unit1;
    assign base_unit2  = r.base_unit2;
    assign osc_pin_dir = r.osc_pin_dir;

endmodule : tmb_timer

`default_nettype wire

// file: src/tmb_defs.svh
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH

// APB register byte offsets
`define TMB_OFF_CTRL       8'h00
`define TMB_OFF_CNT_LO     8'h04
`define TMB_OFF_CNT_HI     8'h08
`define TMB_OFF_IRQ_STAT   8'h0c
`define TMB_OFF_IRQ_CLR    8'h10
`define TMB_OFF_IRQ_EN     8'h14
`define TMB_OFF_AUX        8'h18

// Control register bit positions
`define TMB_B_RUN          0
`define TMB_B_SRC          1
`define TMB_B_SYNC_BYP     2
`define TMB_B_BASE_LO      3
`define TMB_B_PRE_LO       4
`define TMB_B_PRE_HI       5
`define TMB_B_BASE_HI      6
`define TMB_B_WIDE         7

// Auxiliary and interrupt bit positions
`define TMB_B_OSC_EN       0
`define TMB_B_MODE_LO      1
`define TMB_B_MODE_HI      2
`define TMB_B_OVF          0

// Reset values
`define TMB_CTRL_RST       8'h00
`define TMB_CNT_RST        16'h0000
`define TMB_CNT_MAX        16'hffff
`define TMB_BYTE_ZERO      8'h00
`define TMB_WORD_ZERO      32'h0000_0000

// Compare mode code that fires the special event trigger
`define TMB_SPECIAL_EVT    4'hb

// Instruction cycle is four core clocks
`define TMB_CYC_DIV        4
`define TMB_CYC_W          2
`define TMB_PRE_W          3

`endif

// file: src/tmb_pkg.sv
`include "tmb_defs.svh"

package tmb_pkg;

    // Operating mode as derived from source and sync controls
    typedef enum logic [1:0] {
        TMB_MODE_TIMER,
        TMB_MODE_SYNC_CNT,
        TMB_MODE_ASYNC_CNT
    } tmb_mode_t;

    // Clock front-end state
    typedef struct packed {
        logic                  sync1;
        logic                  sync2;
        logic                  prev;
        logic                  armed;
        logic [`TMB_CYC_W-1:0] phase;
        logic                  tick;
    } tmb_front_t;

    // Prescaler state
    typedef struct packed {
        logic [`TMB_PRE_W-1:0] cnt;
        logic                  tick;
    } tmb_presc_t;

    // Timer core state
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] count;
        logic [7:0]  hbuf;
        logic        ovf_stat;
        logic        ovf_en;
        logic        osc_en;
        logic        presc_clr;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        base_unit1;
        logic        base_unit2;
        logic [1:0]  osc_pin_dir;
    } tmb_core_t;

endpackage : tmb_pkg

// file: src/tmb_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tmb_tick_if;
    logic       use_ext;
    logic       sync_bypass;
    logic       run;
    logic       ext_level;
    logic       src_tick;
    logic       clear;
    logic [1:0] ratio;
    logic       out_tick;

    modport core  (output use_ext, sync_bypass, run, ext_level, clear, ratio, input out_tick);
    modport front (input use_ext, sync_bypass, run, ext_level, output src_tick);
    modport presc (input src_tick, clear, ratio, output out_tick);
endinterface : tmb_tick_if

`default_nettype wire

// file: src/tmb_front.sv
`timescale 1ns/1ps
`default_nettype none

module tmb_front
    import tmb_pkg::*;
#(
    parameter int CYC_DIV = `TMB_CYC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Tick path
    tmb_tick_if.front tif
);

    generate
        if (CYC_DIV < 1 || CYC_DIV > (1 << `TMB_CYC_W)) begin : g_chk
            $error("tmb_front: CYC_DIV out of range");
        end
    endgenerate

    localparam logic [`TMB_CYC_W-1:0] PHASE_LAST = `TMB_CYC_W'(CYC_DIV - 1);

    tmb_front_t r;
    tmb_front_t n;
    logic       samp;
    logic       rise;

    assign tif.src_tick = r.tick;

    // Edge qualification and instruction cycle phase
    always_comb begin
        n       = r;
        n.sync1 = tif.ext_level;
        n.sync2 = r.sync1;
        samp    = tif.sync_bypass ? tif.ext_level : r.sync2;
        n.prev  = samp;
        if (r.prev && !samp) begin
            n.armed = 1'b1;
        end
        rise    = r.armed && !r.prev && samp;
        n.phase = (r.phase == PHASE_LAST) ? '0 : r.phase + 1'b1;
        if (tif.use_ext) begin
            n.tick = tif.run && rise;
        end else begin
            n.tick = tif.run && (r.phase == PHASE_LAST);
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : tmb_front

`default_nettype wire

// file: src/tmb_presc.sv
`timescale 1ns/1ps
`default_nettype none

module tmb_presc
    import tmb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Tick path
    tmb_tick_if.presc tif
);

    tmb_presc_t            r;
    tmb_presc_t            n;
    logic [`TMB_PRE_W-1:0] last;

    assign tif.out_tick = r.tick;

    // Divide by 1, 2, 4 or 8
    always_comb begin
        n      = r;
        n.tick = 1'b0;
        last   = `TMB_PRE_W'((1 << tif.ratio) - 1);
        if (tif.clear) begin
            n.cnt = '0;
        end else if (tif.src_tick) begin
            if (r.cnt >= last) begin
                n.cnt  = '0;
                n.tick = 1'b1;
            end else begin
                n.cnt = r.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : tmb_presc

`default_nettype wire

// file: verification/tmb_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none

module tmb_chk
    import tmb_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // Timer side
    input wire logic [3:0]  compare_unit_mode,
    input wire logic        compare_match,
    input wire logic [1:0]  port_c_direction,
    input wire logic [1:0]  osc_pin_dir,
    input wire logic [15:0] count_value,
    input wire logic        base_unit1,
    input wire logic        base_unit2,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_reset_idle: assert property ($rose(nrst) |-> count_value == 16'h0000 && !irq && !pready)
        else $error("outputs busy after reset");
    chk_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_base_both: assert property (base_unit1 |-> base_unit2)
        else $error("unit one base without unit two");
    chk_osc_dir: assert property ($past(nrst) && osc_pin_dir != 2'b11 |-> osc_pin_dir == $past(port_c_direction))
        else $error("pin direction wrong");
    chk_cnt_step: assert property ($changed(count_value) && !$past(psel) && !$past(psel, 2)
        && !$past(compare_match) && !$past(compare_match, 2) |-> count_value == $past(count_value) + 16'h0001)
        else $error("count jumped");
    // irq rises after overflow or enable write
    chk_irq_cause: assert property ($rose(irq) |-> $past(psel) || $past(psel, 2)
        || count_value == 16'h0000 || $past(count_value) == 16'h0000)
        else $error("irq without cause");
    chk_evt_clear: assert property (compare_unit_mode == 4'hb && compare_match && !psel
        |-> ##[1:2] count_value == 16'h0000)
        else $error("event did not clear count");

    // Main scenarios reached
    cov_irq: cover property ($rose(irq));
    cov_evt: cover property (compare_match && compare_unit_mode == 4'hb);
    cov_err: cover property (pslverr);
    cov_base: cover property (base_unit1);
endmodule : tmb_chk

bind tmb_timer tmb_chk tmb_chk_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .compare_unit_mode(compare_unit_mode), .compare_match(compare_match),
    .port_c_direction(port_c_direction), .osc_pin_dir(osc_pin_dir), .count_value(count_value),
    .base_unit1(base_unit1), .base_unit2(base_unit2), .irq(irq));

`default_nettype wire

// file: verification/tmb_partner.sv
`timescale 1ns/1ps
`default_nettype none

module tmb_partner
    import tmb_pkg::*;
(
    // Clock and reset
    input wire logic  clk,
    input wire logic  nrst,
    // Bench controls
    input wire logic  run_ext,
    input wire logic  use_osc,
    input wire logic  fire,
    input wire logic [3:0] mode_sel,
    // Toward the timer
    output logic      external_count_input,
    output logic      secondary_osc_in,
    output logic [3:0] compare_unit_mode,
    output logic      compare_match
);
    logic ph;
    logic wave;
    logic junk;

    // Wave parks low, so a fresh run starts with a rise; junk toggles to catch a wrong input pick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph <= 1'b0;
            wave <= 1'b0;
            junk <= 1'b0;
            compare_match <= 1'b0;
            compare_unit_mode <= 4'h0;
        end else begin
            junk <= ~junk;
            compare_unit_mode <= mode_sel;
            compare_match <= fire;
            if (run_ext || wave) begin
                ph <= ~ph;
                if (ph) wave <= ~wave;
            end
        end
    end

    // Unselected line never looks idle
    assign external_count_input = use_osc ? junk : wave;
    assign secondary_osc_in = use_osc ? wave : junk;
endmodule : tmb_partner

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

module tb
    import tmb_pkg::*;
;
    logic        clk, nrst, psel, penable, pwrite, perr, pready, pslverr;
    logic        ext_in, osc_in, cmatch, run_ext, use_osc, fire, bu1, bu2, irq, sel_d;
    logic [7:0]  paddr, h1, l1, h2;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  cmode, mode_sel;
    logic [1:0]  pcd, pin_dir;
    logic [15:0] cnt, c0;
    int          error_cnt, comparisons, rises, r0;

    tmb_timer tmb_timer_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext_in), .secondary_osc_in(osc_in), .compare_unit_mode(cmode),
        .compare_match(cmatch), .port_c_direction(pcd), .osc_pin_dir(pin_dir), .count_value(cnt),
        .base_unit1(bu1), .base_unit2(bu2), .irq(irq));
    tmb_partner tmb_partner_inst (.clk(clk), .nrst(nrst), .run_ext(run_ext), .use_osc(use_osc), .fire(fire),
        .mode_sel(mode_sel), .external_count_input(ext_in), .secondary_osc_in(osc_in),
        .compare_unit_mode(cmode), .compare_match(cmatch));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Reference count of rises on the selected line
    always @(posedge clk) begin
        if ((use_osc ? osc_in : ext_in) && !sel_d) rises++;
        sel_d = use_osc ? osc_in : ext_in;
    end

    function automatic logic [31:0] exp_base(input logic [1:0] b);
        return b[1] ? 32'h3 : (b[0] ? 32'h1 : 32'h0);
    endfunction : exp_base

    function automatic logic [31:0] exp_aux(input logic osc, input logic byp);
        return {29'h0, byp ? 2'd2 : 2'd1, osc};
    endfunction : exp_aux

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Setup, then access until pready; nothing released before that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        // Let the access edge settle before anyone looks at the count
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd

    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        mode_sel <= m;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        #(8 * 40000);
        $display("Error at %0t: watchdog expired", $time);
        error_cnt++;
        final_report();
    end

    initial begin
        {nrst, psel, penable, pwrite, run_ext, use_osc, fire, sel_d} = 8'h00;
        {paddr, pwdata, mode_sel} = 44'h0;
        error_cnt = 0;
        comparisons = 0;
        rises = 0;
        void'($urandom(9928));
        pcd = 2'($urandom);
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(`TMB_OFF_CTRL, 32'h0);
        rd(`TMB_OFF_CNT_LO, 32'h0);
        rd(`TMB_OFF_AUX, 32'h0);
        rd(`TMB_OFF_IRQ_CLR, 32'h0);
        rd(8'h1c, 32'h0);
        chk({31'h0, perr}, 32'h1);
        $display("reset test done");
        for (int b = 0; b < 4; b++) begin
            wr(`TMB_OFF_CTRL, {1'b0, b[1], 2'b00, b[0], 3'b000});
            repeat (2) @(posedge clk);
            chk({30'h0, bu1, bu2}, exp_base(b[1:0]));
        end
        $display("base test done");
        // wide access buffers the high byte
        h1 = 8'($urandom);
        l1 = 8'($urandom);
        h2 = ~h1;
        wr(`TMB_OFF_CTRL, 8'h80);
        wr(`TMB_OFF_CNT_HI, h1);
        wr(`TMB_OFF_CNT_LO, l1);
        chk({16'h0, cnt}, {16'h0, h1, l1});
        wr(`TMB_OFF_CNT_HI, h2);
        chk({16'h0, cnt}, {16'h0, h1, l1});
        rd(`TMB_OFF_CNT_LO, {24'h0, l1});
        rd(`TMB_OFF_CNT_HI, {24'h0, h1});
        wr(`TMB_OFF_CTRL, 8'h00);
        wr(`TMB_OFF_CNT_HI, h2);
        chk({16'h0, cnt}, {16'h0, h2, l1});
        $display("wide test done");
        // one step per four clocks times the ratio
        for (int ps = 0; ps < 4; ps++) begin
            wr(`TMB_OFF_CTRL, {2'b00, ps[1:0], 1'b0, 1'($urandom), 2'b01});
            repeat (40) @(posedge clk);
            c0 = cnt;
            repeat (20 << ps) @(posedge clk);
            chk({16'h0, cnt - c0}, 32'h5);
        end
        // run bit cleared holds the count
        wr(`TMB_OFF_CTRL, 8'h30);
        repeat (8) @(posedge clk);
        c0 = cnt;
        repeat (40) @(posedge clk);
        chk({16'h0, cnt}, {16'h0, c0});
        $display("prescale test done");
        // wrap, masked then enabled irq, clear
        wr(`TMB_OFF_CTRL, 8'h00);
        wr(`TMB_OFF_CNT_HI, 8'hff);
        wr(`TMB_OFF_CNT_LO, 8'hfd);
        wr(`TMB_OFF_CTRL, 8'h01);
        repeat (40) @(posedge clk);
        rd(`TMB_OFF_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, cnt < 16'h0040}, 32'h1);
        wr(`TMB_OFF_IRQ_EN, 8'h01);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(`TMB_OFF_IRQ_CLR, 8'h01);
        wr(`TMB_OFF_IRQ_STAT, 8'h01);
        rd(`TMB_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("overflow test done");
        // event reset fires for mode 1011 only
        wr(`TMB_OFF_CNT_HI, 8'h40);
        pulse(4'ha);
        chk({24'h0, cnt[15:8]}, 32'h40);
        pulse(4'hb);
        chk({31'h0, cnt < 16'h0002}, 32'h1);
        rd(`TMB_OFF_IRQ_STAT, 32'h0);
        $display("event test done");
        // external modes, first rise ignored once
        for (int i = 0; i < 4; i++) begin
            use_osc <= i[1];
            pcd <= 2'($urandom);
            wr(`TMB_OFF_AUX, {7'h0, i[1]});
            wr(`TMB_OFF_CTRL, {5'h0, i[0], 2'b11});
            wr(`TMB_OFF_CNT_HI, 8'h00);
            wr(`TMB_OFF_CNT_LO, 8'h00);
            @(negedge clk) r0 = rises;
            @(posedge clk) run_ext <= 1'b1;
            repeat (48) @(posedge clk);
            run_ext <= 1'b0;
            repeat (12) @(posedge clk);
            chk({16'h0, cnt}, 32'(rises - r0 - (i == 0)));
            rd(`TMB_OFF_AUX, exp_aux(i[1], i[0]));
            if (i[1]) chk({30'h0, pin_dir}, 32'h3);
        end
        $display("external test done");
        final_report();
    end
endmodule : tb

`default_nettype wire
